// ===== hdl/osgm_top.sv
// top: command registers, turn-on sequencer and output-good monitor
`timescale 1ns/10ps
module osgm_top #(
  parameter int MS_CYCLES = osgm_pkg::OSGM_MS_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // command port
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  // converter side
  input wire logic enable,
  input wire logic [15:0] vout,
  input wire logic uv_reached,
  input wire logic pin_function_setup,
  input wire logic fault_clear,
  output logic output_on,
  output logic ramp_active,
  output logic output_ok_indication,
  output logic good_status,
  output logic timeout_fault
);
  import osgm_pkg::*;

  function automatic logic [7:0] osgm_pow2(input logic [2:0] n);
    osgm_pow2 = 8'h01 << n;
  endfunction

  osgm_tick_if tk();
  osgm_ms_base #(.MS_CYCLES(MS_CYCLES)) u_base (.clk(clk), .nrst(nrst), .tick(tk));

  logic [15:0] assert_ff, negate_ff, wait_ff, ramp_ff, limit_ff, unit_ff;
  logic [7:0] resp_ff;
  logic [15:0] nxt_assert, nxt_negate, nxt_wait, nxt_ramp, nxt_limit, nxt_unit;
  logic [7:0] nxt_resp;

  always_comb begin
    nxt_assert = assert_ff;
    nxt_negate = negate_ff;
    nxt_wait = wait_ff;
    nxt_ramp = ramp_ff;
    nxt_limit = limit_ff;
    nxt_unit = unit_ff;
    nxt_resp = resp_ff;
    if (cmd_wr) begin
      case (cmd_code)
        OSGM_CMD_GOOD_ASSERT: nxt_assert = cmd_wdata;
        OSGM_CMD_GOOD_NEGATE: nxt_negate = cmd_wdata;
        OSGM_CMD_TURN_ON_WAIT: nxt_wait = cmd_wdata;
        OSGM_CMD_RAMP: nxt_ramp = cmd_wdata;
        OSGM_CMD_TIMEOUT: nxt_limit = cmd_wdata;
        OSGM_CMD_TIME_UNIT: nxt_unit = cmd_wdata;
        OSGM_CMD_RESPONSE: nxt_resp = cmd_wdata[7:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    case (cmd_code)
      OSGM_CMD_GOOD_ASSERT: cmd_rdata = assert_ff;
      OSGM_CMD_GOOD_NEGATE: cmd_rdata = negate_ff;
      OSGM_CMD_TURN_ON_WAIT: cmd_rdata = wait_ff;
      OSGM_CMD_RAMP: cmd_rdata = ramp_ff;
      OSGM_CMD_TIMEOUT: cmd_rdata = limit_ff;
      OSGM_CMD_TIME_UNIT: cmd_rdata = unit_ff;
      OSGM_CMD_RESPONSE: cmd_rdata = {8'h00, resp_ff};
      default: cmd_rdata = 16'h0000;
    endcase
  end

  // sequencer state
  osgm_state_t st_ff, nxt_st;
  logic [15:0] ms_ff, nxt_ms;
  logic [15:0] to_ff, nxt_to;
  logic [15:0] unit_cnt_ff, nxt_unit_cnt;
  logic [7:0] du_ff, nxt_du;
  logic [2:0] tries_ff, nxt_tries;
  logic tofault_ff, nxt_tofault;
  logic good_ff, nxt_good;
  logic gstat_ff, nxt_gstat;

  logic [1:0] resp;
  logic [2:0] retries;
  logic [7:0] delay_units;
  logic tick;
  logic unit_done;
  logic expired;
  logic may_retry;
  assign resp = resp_ff[OSGM_RESP_HI:OSGM_RESP_LO];
  assign retries = resp_ff[OSGM_RETRY_HI:OSGM_RETRY_LO];
  assign delay_units = osgm_pow2(resp_ff[OSGM_DELAY_HI:OSGM_DELAY_LO]);
  assign tick = tk.ms_tick;
  // unit length in ms; zero treated as one so the hold never stalls
  assign unit_done = tick && (unit_cnt_ff + 16'h1 >= unit_ff);
  assign expired = (limit_ff != 16'h0) && tick && (to_ff + 16'h1 >= limit_ff);
  assign may_retry = (retries == OSGM_RETRY_FOREVER) || (tries_ff < retries);

  always_comb begin
    nxt_st = st_ff;
    nxt_ms = ms_ff;
    nxt_to = to_ff;
    nxt_unit_cnt = unit_cnt_ff;
    nxt_du = du_ff;
    nxt_tries = tries_ff;
    nxt_tofault = tofault_ff;
    if (fault_clear) begin
      nxt_tofault = 1'b0;
    end
    case (st_ff)
      OSGM_OFF: begin
        nxt_tries = 3'h0;
        if (enable && !tofault_ff) begin
          nxt_st = OSGM_WAIT;
          nxt_ms = 16'h0;
        end
      end
      OSGM_WAIT: begin
        if (!enable) begin
          nxt_st = OSGM_OFF;
        end else if (ms_ff >= wait_ff) begin
          nxt_st = OSGM_RAMP;
          nxt_ms = 16'h0;
          nxt_to = 16'h0;
        end else if (tick) begin
          nxt_ms = ms_ff + 16'h1;
        end
      end
      OSGM_RAMP: begin
        if (tick) begin
          nxt_to = to_ff + 16'h1;
          if (ms_ff < ramp_ff) begin
            nxt_ms = ms_ff + 16'h1;
          end
        end
        if (!enable) begin
          nxt_st = OSGM_OFF;
        end else if (uv_reached) begin
          nxt_st = OSGM_ON;
        end else if (expired) begin
          nxt_tofault = 1'b1;
          nxt_unit_cnt = 16'h0;
          nxt_du = 8'h0;
          case (resp)
            OSGM_RESP_IGNORE: nxt_st = OSGM_ON;
            OSGM_RESP_RUN_ON: nxt_st = OSGM_HOLD;
            OSGM_RESP_RETRY: nxt_st = may_retry ? OSGM_HOLD : OSGM_LATCHED;
            default: nxt_st = OSGM_LATCHED;
          endcase
        end
      end
      OSGM_ON: begin
        if (!enable) begin
          nxt_st = OSGM_OFF;
        end
      end
      OSGM_HOLD: begin
        // run-on keeps output up, retry keeps it off, for the decoded count
        if (!enable) begin
          nxt_st = OSGM_OFF;
        end else if (unit_done) begin
          nxt_unit_cnt = 16'h0;
          if (du_ff + 8'h1 >= delay_units) begin
            if (resp == OSGM_RESP_RUN_ON && !may_retry) begin
              nxt_st = OSGM_LATCHED;
            end else begin
              nxt_st = OSGM_WAIT;
              nxt_ms = 16'h0;
              if (retries != OSGM_RETRY_FOREVER) begin
                nxt_tries = tries_ff + 3'h1;
              end
            end
          end else begin
            nxt_du = du_ff + 8'h1;
          end
        end else if (tick) begin
          nxt_unit_cnt = unit_cnt_ff + 16'h1;
        end
      end
      OSGM_LATCHED: begin
        if (!enable || fault_clear) begin
          nxt_st = OSGM_OFF;
        end
      end
      default: nxt_st = OSGM_OFF;
    endcase
  end

  // output-good monitor with hysteresis between the two levels
  always_comb begin
    nxt_good = good_ff;
    nxt_gstat = 1'b0;
    if (st_ff == OSGM_ON || st_ff == OSGM_RAMP || st_ff == OSGM_HOLD) begin
      if (vout >= assert_ff) begin
        nxt_good = 1'b1;
      end else if (vout < negate_ff) begin
        nxt_good = 1'b0;
      end
    end else begin
      nxt_good = 1'b0;
    end
    if (vout < negate_ff) begin
      nxt_gstat = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      assert_ff <= OSGM_WORD_RESET;
      negate_ff <= OSGM_WORD_RESET;
      wait_ff <= OSGM_WORD_RESET;
      ramp_ff <= OSGM_WORD_RESET;
      limit_ff <= OSGM_WORD_RESET;
      unit_ff <= OSGM_UNIT_RESET;
      resp_ff <= OSGM_BYTE_RESET;
      st_ff <= OSGM_OFF;
      ms_ff <= 16'h0;
      to_ff <= 16'h0;
      unit_cnt_ff <= 16'h0;
      du_ff <= 8'h0;
      tries_ff <= 3'h0;
      tofault_ff <= 1'b0;
      good_ff <= 1'b0;
      gstat_ff <= 1'b0;
    end else begin
      assert_ff <= nxt_assert;
      negate_ff <= nxt_negate;
      wait_ff <= nxt_wait;
      ramp_ff <= nxt_ramp;
      limit_ff <= nxt_limit;
      unit_ff <= nxt_unit;
      resp_ff <= nxt_resp;
      st_ff <= nxt_st;
      ms_ff <= nxt_ms;
      to_ff <= nxt_to;
      unit_cnt_ff <= nxt_unit_cnt;
      du_ff <= nxt_du;
      tries_ff <= nxt_tries;
      tofault_ff <= nxt_tofault;
      good_ff <= nxt_good;
      gstat_ff <= nxt_gstat;
    end
  end

  assign output_on = (st_ff == OSGM_RAMP) || (st_ff == OSGM_ON)
    || (st_ff == OSGM_HOLD && resp == OSGM_RESP_RUN_ON);
  assign ramp_active = (st_ff == OSGM_RAMP) && (ms_ff < ramp_ff);
  assign output_ok_indication = good_ff && pin_function_setup;
  assign good_status = gstat_ff;
  assign timeout_fault = tofault_ff;
endmodule // osgm_top

// ===== hdl/osgm_pkg.sv
// package: command codes, fields and timing constants of the start-up and output-good monitor
package osgm_pkg;
  localparam logic [7:0] OSGM_CMD_GOOD_ASSERT = 8'h5E;
  localparam logic [7:0] OSGM_CMD_GOOD_NEGATE = 8'h5F;
  localparam logic [7:0] OSGM_CMD_TURN_ON_WAIT = 8'h60;
  localparam logic [7:0] OSGM_CMD_RAMP = 8'h61;
  localparam logic [7:0] OSGM_CMD_TIMEOUT = 8'h62;
  localparam logic [7:0] OSGM_CMD_RESPONSE = 8'h63;
  localparam logic [7:0] OSGM_CMD_TIME_UNIT = 8'hD2;
  localparam logic [15:0] OSGM_WORD_RESET = 16'h0000;
  localparam logic [7:0] OSGM_BYTE_RESET = 8'h00;
  localparam logic [15:0] OSGM_UNIT_RESET = 16'h0001;
  localparam int OSGM_RESP_HI = 7;
  localparam int OSGM_RESP_LO = 6;
  localparam int OSGM_RETRY_HI = 5;
  localparam int OSGM_RETRY_LO = 3;
  localparam int OSGM_DELAY_HI = 2;
  localparam int OSGM_DELAY_LO = 0;
  localparam logic [1:0] OSGM_RESP_IGNORE = 2'h0;
  localparam logic [1:0] OSGM_RESP_RUN_ON = 2'h1;
  localparam logic [1:0] OSGM_RESP_RETRY = 2'h2;
  localparam logic [1:0] OSGM_RESP_LATCH = 2'h3;
  localparam logic [2:0] OSGM_RETRY_FOREVER = 3'h7;
  localparam int OSGM_CLK_MHZ = 100;
  localparam int OSGM_MS_US = 1000;
  localparam int OSGM_MS_CYCLES = OSGM_CLK_MHZ * OSGM_MS_US;
  typedef enum logic [5:0] {
    OSGM_OFF = 6'h01,
    OSGM_WAIT = 6'h02,
    OSGM_RAMP = 6'h04,
    OSGM_ON = 6'h08,
    OSGM_HOLD = 6'h10,
    OSGM_LATCHED = 6'h20
  } osgm_state_t;
endpackage

// ===== hdl/osgm_tick_if.sv
// interface: millisecond tick between the top and the time base
`timescale 1ns/10ps
interface osgm_tick_if;
  logic ms_tick;
  modport src (output ms_tick);
  modport dst (input ms_tick);
endinterface

// ===== hdl/osgm_ms_base.sv
// time base: one-cycle pulse per millisecond
`timescale 1ns/10ps
module osgm_ms_base #(
  parameter int MS_CYCLES = osgm_pkg::OSGM_MS_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // tick out
  osgm_tick_if.src tick
);
  import osgm_pkg::*;
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  always_comb begin
    if (cnt_ff == 32'(MS_CYCLES - 1)) begin
      nxt_cnt = 32'h0;
    end else begin
      nxt_cnt = cnt_ff + 32'h1;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 32'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  assign tick.ms_tick = (cnt_ff == 32'(MS_CYCLES - 1));
endmodule // osgm_ms_base

// ===== bench/osgm_host_model.sv
// partner: command-port host issuing word writes and reads
`timescale 1ns/10ps
module osgm_host_model (
  // clock
  input wire logic clk,
  // command port
  output logic [7:0] cmd_code,
  output logic cmd_wr,
  output logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata
);
  initial begin
    cmd_code = 8'h00;
    cmd_wr = 1'b0;
    cmd_wdata = 16'h0000;
  end
  // whole words only; strobe lasts one cycle
  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    @(negedge clk);
    cmd_code = c;
    cmd_wdata = v;
    cmd_wr = 1'b1;
    @(negedge clk);
    cmd_wr = 1'b0;
    // stale data must not look valid
    cmd_wdata = ~v;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] v);
    @(negedge clk);
    cmd_code = c;
    @(posedge clk);
    v = cmd_rdata;
  endtask
endmodule // osgm_host_model

// ===== bench/osgm_top_asserts.sv
// checker: port-level properties of the start-up and output-good monitor
`timescale 1ns/10ps
module osgm_top_asserts #(
  parameter int MS_CYCLES = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // command port
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata,
  // converter side
  input wire logic enable,
  input wire logic [15:0] vout,
  input wire logic uv_reached,
  input wire logic pin_function_setup,
  input wire logic fault_clear,
  input wire logic output_on,
  input wire logic ramp_active,
  input wire logic output_ok_indication,
  input wire logic good_status,
  input wire logic timeout_fault
);
  import osgm_pkg::*;
  logic [15:0] asrt_ff, neg_ff, lim_ff;
  // shadows of the thresholds, rebuilt from the write strobes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      asrt_ff <= 16'h0000;
      neg_ff <= 16'h0000;
      lim_ff <= 16'h0000;
    end else if (cmd_wr) begin
      if (cmd_code == OSGM_CMD_GOOD_ASSERT) asrt_ff <= cmd_wdata;
      if (cmd_code == OSGM_CMD_GOOD_NEGATE) neg_ff <= cmd_wdata;
      if (cmd_code == OSGM_CMD_TIMEOUT) lim_ff <= cmd_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_unmapped_reads_zero: assert property (!(cmd_code inside {[8'h5E:8'h63], 8'hD2})
    |-> cmd_rdata == 16'h0000) else $error("unmapped read not zero");
  a_word_write_kept: assert property (cmd_wr && cmd_code inside {[8'h5E:8'h62]}
    ##1 $stable(cmd_code) |-> cmd_rdata == $past(cmd_wdata)) else $error("word lost");
  a_ok_needs_pin: assert property (output_ok_indication |-> pin_function_setup)
    else $error("good shown with pin disabled");
  a_ok_rise_level: assert property ($rose(output_ok_indication) && $past(pin_function_setup)
    |-> $past(vout >= asrt_ff)) else $error("good rose below assert level");
  a_ok_drop_below: assert property (vout < neg_ff && vout < asrt_ff
    |=> !output_ok_indication) else $error("good kept below negate level");
  a_status_follows: assert property (1'b1 |=> good_status == $past(vout < neg_ff))
    else $error("status bit wrong");
  a_fault_sticky: assert property (timeout_fault && !fault_clear |=> timeout_fault)
    else $error("fault dropped without clear");
  a_fault_in_ramp: assert property ($rose(timeout_fault)
    |-> $past(output_on) && !$past(uv_reached)) else $error("fault outside start-up");
  a_zero_limit_none: assert property (lim_ff == 16'h0000 && !timeout_fault
    |=> !timeout_fault) else $error("fault with zero limit");
  a_off_when_disabled: assert property (!enable |=> !output_on)
    else $error("output on without enable");
  c_turn_on: cover property ($rose(output_on));
  c_timeout: cover property ($rose(timeout_fault));
  c_good: cover property ($rose(output_ok_indication));
endmodule // osgm_top_asserts
bind osgm_top osgm_top_asserts #(.MS_CYCLES(MS_CYCLES)) i_chk (.clk(clk), .nrst(nrst),
  .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
  .enable(enable), .vout(vout), .uv_reached(uv_reached),
  .pin_function_setup(pin_function_setup), .fault_clear(fault_clear),
  .output_on(output_on), .ramp_active(ramp_active),
  .output_ok_indication(output_ok_indication), .good_status(good_status),
  .timeout_fault(timeout_fault));

// ===== bench/osgm_top_tb.sv
// testbench: registers, sequencing, good monitor and timeout scenarios
`timescale 1ns/10ps
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("FAIL %s exp %0h got %0h", nm, e, s); end end
module osgm_top_tb;
  import osgm_pkg::*;
  localparam int MSC = 10;
  logic clk = 1'b0, nrst = 1'b0, enable = 1'b0, uv_reached = 1'b0, fault_clear = 1'b0;
  logic pin_function_setup = 1'b1, cmd_wr;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, d, vout = 16'h0000;
  logic output_on, ramp_active, output_ok_indication, good_status, timeout_fault;
  int bad_count = 0, num_checks = 0, n;
  osgm_host_model i_host (.clk(clk), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata));
  osgm_top #(.MS_CYCLES(MSC)) i_dut (.clk(clk), .nrst(nrst), .cmd_code(cmd_code),
    .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .enable(enable),
    .vout(vout), .uv_reached(uv_reached), .pin_function_setup(pin_function_setup),
    .fault_clear(fault_clear), .output_on(output_on), .ramp_active(ramp_active),
    .output_ok_indication(output_ok_indication), .good_status(good_status),
    .timeout_fault(timeout_fault));
  initial forever #5 clk = ~clk;
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // bounded wait: 0 output_on, 1 timeout_fault, 2 ramp_active
  task wt(input int sel, input logic want, output int k);
    k = 0;
    while ((sel == 0 ? output_on : sel == 1 ? timeout_fault : ramp_active) !== want
      && k < 400) begin
      @(negedge clk);
      k++;
    end
  endtask
  task t_regs;
    i_host.rd(OSGM_CMD_TURN_ON_WAIT, d);
    `CHK("wait reset", 16'h0000, d)
    i_host.rd(OSGM_CMD_TIME_UNIT, d);
    `CHK("unit reset", 16'h0001, d)
    for (int i = 0; i < 5; i++) begin
      i_host.wr(8'h5E + i[7:0], 16'hA5C3 ^ i[15:0]);
      i_host.rd(8'h5E + i[7:0], d);
      `CHK("word", 16'hA5C3 ^ i[15:0], d)
    end
    i_host.wr(8'h40, 16'hFFFF);
    i_host.rd(8'h40, d);
    `CHK("unmapped", 16'h0000, d)
  endtask
  task t_seq;
    i_host.wr(OSGM_CMD_TURN_ON_WAIT, 16'h0002);
    i_host.wr(OSGM_CMD_RAMP, 16'h0001);
    i_host.wr(OSGM_CMD_TIMEOUT, 16'h0000);
    i_host.wr(OSGM_CMD_GOOD_ASSERT, 16'h8000);
    i_host.wr(OSGM_CMD_GOOD_NEGATE, 16'h6000);
    @(negedge clk);
    `CHK("below", 1'b1, good_status)
    enable = 1'b1;
    wt(0, 1'b1, n);
    `CHK("wait span", 1'b1, n >= MSC && n <= 3 * MSC + 2)
    `CHK("ramping", 1'b1, ramp_active)
    wt(2, 1'b0, n);
    `CHK("ramp span", 1'b1, n > 0 && n <= 2 * MSC + 2)
    repeat (6 * MSC) @(negedge clk);
    `CHK("no limit", 1'b0, timeout_fault)
    uv_reached = 1'b1;
    vout = 16'h9000;
    repeat (2) @(negedge clk);
    `CHK("good on", 1'b1, output_ok_indication)
    pin_function_setup = 1'b0;
    @(negedge clk);
    `CHK("pin off", 1'b0, output_ok_indication)
    pin_function_setup = 1'b1;
    vout = 16'h5000;
    repeat (2) @(negedge clk);
    `CHK("good off", 1'b0, output_ok_indication)
    `CHK("status", 1'b1, good_status)
    enable = 1'b0;
    uv_reached = 1'b0;
    @(negedge clk);
  endtask
  task t_fault(input logic [15:0] rsp, input logic [15:0] lim, input logic [15:0] unit);
    i_host.wr(OSGM_CMD_TIMEOUT, lim);
    i_host.wr(OSGM_CMD_RESPONSE, rsp);
    i_host.wr(OSGM_CMD_TIME_UNIT, unit);
    enable = 1'b1;
  endtask
  task t_latch;
    t_fault(16'h00C0, 16'h0003, 16'h0001);
    wt(0, 1'b1, n);
    wt(1, 1'b1, n);
    `CHK("limit span", 1'b1, n >= 2 * MSC && n <= 4 * MSC + 2)
    repeat (2) @(negedge clk);
    `CHK("latched off", 1'b0, output_on)
    enable = 1'b0;
    fault_clear = 1'b1;
    @(negedge clk);
    fault_clear = 1'b0;
    @(negedge clk);
    `CHK("cleared", 1'b0, timeout_fault)
  endtask
  task t_retry;
    // zero turn-on wait so the gap is the restart spacing alone
    i_host.wr(OSGM_CMD_TURN_ON_WAIT, 16'h0000);
    t_fault(16'h0088, 16'h0001, 16'h0002);
    wt(1, 1'b1, n);
    wt(0, 1'b0, n);
    wt(0, 1'b1, n);
    `CHK("retry gap", 1'b1, n > MSC && n <= 2 * MSC + 5)
    enable = 1'b0;
    fault_clear = 1'b1;
    @(negedge clk);
    fault_clear = 1'b0;
  endtask
  task off_clear;
    enable = 1'b0;
    fault_clear = 1'b1;
    @(negedge clk);
    fault_clear = 1'b0;
  endtask
  task t_runon;
    // field 1 gives two units of run-on, no retries left, then off
    t_fault(16'hFF41, 16'h0001, 16'h0001);
    i_host.rd(OSGM_CMD_RESPONSE, d);
    `CHK("resp byte", 16'h0041, d)
    wt(1, 1'b1, n);
    `CHK("run on", 1'b1, output_on)
    wt(0, 1'b0, n);
    `CHK("run-on span", 1'b1, n > MSC && n <= 2 * MSC + 2)
    off_clear;
    // ignore response keeps the output up despite the fault
    t_fault(16'h0000, 16'h0001, 16'h0001);
    wt(1, 1'b1, n);
    repeat (2) @(negedge clk);
    `CHK("ignore on", 1'b1, output_on)
    off_clear;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    t_regs;
    t_seq;
    t_latch;
    t_retry;
    t_runon;
    summarize;
  end
  // whole run is under 500 cycles
  initial begin
    #100000;
    bad_count++;
    summarize;
  end
endmodule // osgm_top_tb
